// >>> src/idpb_map.svh
`ifndef IDPB_MAP_SVH
`define IDPB_MAP_SVH

// word addresses in the identification block
`define IDPB_W_GENCFG     8'd0
`define IDPB_W_DFLT_CYL   8'd1
`define IDPB_W_DFLT_HEAD  8'd3
`define IDPB_W_DFLT_SPT   8'd6
`define IDPB_W_CARD_LO    8'd7
`define IDPB_W_CARD_HI    8'd8
`define IDPB_W_SER_FIRST  8'd10
`define IDPB_W_SER_LAST   8'd19
`define IDPB_W_FW_FIRST   8'd23
`define IDPB_W_FW_LAST    8'd26
`define IDPB_W_MOD_FIRST  8'd27
`define IDPB_W_MOD_LAST   8'd46
`define IDPB_W_MAX_MULT   8'd47
`define IDPB_W_CAPS       8'd49
`define IDPB_W_CAPS2      8'd50
`define IDPB_W_PIO_MODE   8'd51
`define IDPB_W_VALID      8'd53
`define IDPB_W_CUR_CYL    8'd54
`define IDPB_W_CUR_HEAD   8'd55
`define IDPB_W_CUR_SPT    8'd56
`define IDPB_W_CAP_LO     8'd57
`define IDPB_W_CAP_HI     8'd58
`define IDPB_W_MULT_SET   8'd59
`define IDPB_W_LBA_LO     8'd60
`define IDPB_W_LBA_HI     8'd61
`define IDPB_W_MDMA       8'd63
`define IDPB_W_ADV_PIO    8'd64
`define IDPB_W_MDMA_MIN   8'd65
`define IDPB_W_MDMA_REC   8'd66
`define IDPB_W_PIO_MIN    8'd67
`define IDPB_W_PIO_IORDY  8'd68
`define IDPB_W_UDMA       8'd88
`define IDPB_W_ADV_TIME   8'd163
`define IDPB_W_LAST       8'd255

// fixed values and field positions
`define IDPB_GENCFG_REMOV 16'h848a
`define IDPB_GENCFG_FIXED 16'h045a
`define IDPB_MAX_MULT_HI  8'h80
`define IDPB_CAPS2_VAL    16'h4001
`define IDPB_PIO_MODE_HI  8'h02
`define IDPB_VALID_VAL    16'h0007
`define IDPB_MULT_VALID   8'h01
`define IDPB_CAP_IORDY    11
`define IDPB_CAP_LBA      9
`define IDPB_CAP_DMA      8
`define IDPB_MDMA_TOP     3'd2
`define IDPB_PIO3         3'd3
`define IDPB_PIO4         3'd4
`define IDPB_SPACE        8'h20
`define IDPB_SIG          8'ha5
`define IDPB_MDMA_FLOOR   16'h0078

`endif

// >>> src/idpb_pkg.sv
package idpb_pkg;

    // transfer sequencer states
    typedef enum logic {
        IDPB_IDLE,
        IDPB_XFER
    } idpb_state_t;

    // string justification inside a fixed-length field
    typedef enum logic {
        IDPB_LEFT,
        IDPB_RIGHT
    } idpb_just_t;

endpackage : idpb_pkg

// >>> src/idpb_str_word.sv
`timescale 1ns/1ps
`include "idpb_map.svh"

module idpb_str_word #(
    parameter int                  P_CHARS = 20,
    parameter idpb_pkg::idpb_just_t P_JUST = idpb_pkg::IDPB_LEFT
) (
    input  wire logic [P_CHARS*8-1:0]         i_str,  // char 0 in bits 7:0
    input  wire logic [$clog2(P_CHARS+1)-1:0] i_len,  // characters in use
    input  wire logic [$clog2(P_CHARS/2)-1:0] i_word, // word inside field
    output logic      [15:0]                  o_word  // first char high byte
);

    // one character of the padded field; a length above the field is clipped
    function automatic logic [7:0] char_at(input int pos, input int len);
        int pad;
        int src;
        logic ok;
        begin
            if (len > P_CHARS)
                len = P_CHARS;
            pad = P_CHARS - len;
            if (P_JUST == idpb_pkg::IDPB_LEFT)
            begin
                ok  = (pos < len);
                src = pos;
            end
            else
            begin
                ok  = (pos >= pad);
                src = pos - pad;
            end
            if (!ok)
                char_at = `IDPB_SPACE;
            else
                char_at = i_str[src*8 +: 8];
        end
    endfunction : char_at

    // two characters per word, earlier one in the upper byte
    always_comb
    begin
        o_word = {char_at(2 * int'(i_word), int'(i_len)),
                  char_at(2 * int'(i_word) + 1, int'(i_len))};
    end

endmodule : idpb_str_word

// >>> src/idpb_top.sv
`timescale 1ns/1ps
`include "idpb_map.svh"

// Notes on behaviour
// - word 0 reads 848a outside true ide mode
// - word 0 reads 045a, non-removable, in true ide mode
// - words 7-8 carry total card sectors
// - serial number words 10-19 are right justified and space padded
// - model number words 27-46 are left justified and space padded
// - word 49 bit 13 always reads zero
// - word 49 bit 11 flags iordy support, bit 10 always reads zero
// - word 49 bit 9 flags lba support, bit 8 flags dma commands
// - word 51 upper byte holds two, the highest legacy pio mode
// - word 53 bits 0, 1 and 2 mark words 54-58, 64-70 and 88 valid
// - words 57-58 hold cyl x head x spt product
// - word 59 reads 01 in upper byte, lower byte zero or one
// - word 63 upper byte one-hot for selected mdma mode 0-2 in true ide mode
// - word 63 lower byte flags supported mdma modes cumulatively, in true ide with dma support
// - mdma modes above 2 and pio above 4 appear only in word 163
// - word 65 minimum mdma cycle, not below the floor
// - word 66 recommended mdma cycle, never below word 65
// - word 67 minimum pio cycle, not below word 68
// - unsupported cycle-time words 65-67 read zero
// - word 88 is zero outside true ide or without udma
module idpb_top #(
    parameter logic [15:0] P_MDMA_FLOOR_NS = `IDPB_MDMA_FLOOR
) (
    input  wire logic         i_clk,           // controller clock
    input  wire logic         i_rst_b,         // async reset, active low
    input  wire logic         i_start,         // identify command pulse
    input  wire logic         i_ready,         // host takes the word
    output logic              o_valid,         // word on o_data is offered
    output logic      [15:0]  o_data,          // current word, registered
    output logic      [7:0]   o_index,         // its word address
    output logic              o_last,          // offered word is 255
    output logic              o_done,          // pulse after word 255 taken
    input  wire logic         i_true_ide,      // true ide mode, else card modes
    input  wire logic [15:0]  i_dflt_cyl,      // default cylinders
    input  wire logic [15:0]  i_dflt_head,     // default heads
    input  wire logic [15:0]  i_dflt_spt,      // default sectors per track
    input  wire logic [15:0]  i_cur_cyl,       // current cylinders
    input  wire logic [15:0]  i_cur_head,      // current heads
    input  wire logic [15:0]  i_cur_spt,       // current sectors per track
    input  wire logic [31:0]  i_total_sectors, // sectors per card
    input  wire logic [159:0] i_serial,        // serial chars, char 0 low
    input  wire logic [4:0]   i_serial_len,    // serial chars in use
    input  wire logic [63:0]  i_fw_rev,        // firmware revision chars
    input  wire logic [319:0] i_model,         // model chars, char 0 low
    input  wire logic [5:0]   i_model_len,     // model chars in use
    input  wire logic [7:0]   i_max_multiple,  // max sectors per multiple
    input  wire logic [7:0]   i_mult_setting,  // current multiple setting
    input  wire logic         i_iordy_sup,     // iordy supported
    input  wire logic         i_dma_sup,       // dma commands supported
    input  wire logic [2:0]   i_mdma_sup_max,  // fastest mdma mode supported
    input  wire logic         i_mdma_sel_en,   // an mdma mode is selected
    input  wire logic [2:0]   i_mdma_sel,      // selected mdma mode
    input  wire logic [2:0]   i_pio_max,       // fastest pio mode supported
    input  wire logic         i_mdma_cyc_sup,  // words 65-66 supported
    input  wire logic [15:0]  i_mdma_min_ns,   // minimum mdma cycle, ns
    input  wire logic [15:0]  i_mdma_rec_ns,   // recommended mdma cycle, ns
    input  wire logic         i_pio_cyc_sup,   // word 67 supported
    input  wire logic [15:0]  i_pio_min_ns,    // pio cycle without iordy, ns
    input  wire logic [15:0]  i_pio_iordy_ns,  // pio cycle with iordy, ns
    input  wire logic         i_udma_sup,      // udma supported in true ide
    input  wire logic [15:0]  i_udma_word,     // udma support and selection
    input  wire logic [15:0]  i_adv_timing     // advanced timing word 163
);

    idpb_pkg::idpb_state_t state_reg;
    idpb_pkg::idpb_state_t state_next;
    logic [7:0]            idx_reg;
    logic [7:0]            idx_next;
    logic [15:0]           data_reg;
    logic [15:0]           data_next;
    logic [7:0]            sum_reg;
    logic [7:0]            sum_next;
    logic [31:0]           cap_reg;
    logic [31:0]           cap_next;
    logic                  done_reg;
    logic                  done_next;
    logic [7:0]            word_addr;
    logic [15:0]           word_val;
    logic [7:0]            sum_acc;
    logic [15:0]           ser_word;
    logic [15:0]           mod_word;
    logic [15:0]           fw_word;
    logic                  take;

    // larger of two cycle times
    function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
        max16 = (a > b) ? a : b;
    endfunction : max16

    // cumulative support flags, bit n set when mode n or faster is there
    function automatic logic [7:0] thermo(input logic [2:0] top);
        logic [7:0] t;
        begin
            t = 8'h00;
            for (int i = 0; i <= int'(`IDPB_MDMA_TOP); i++)
                if (3'(i) <= top)
                    t[i] = 1'b1;
            thermo = t;
        end
    endfunction : thermo

    // string fields, each justified as its field demands
    idpb_str_word #(
        .P_CHARS (20),
        .P_JUST  (idpb_pkg::IDPB_RIGHT)
    ) u_serial (
        .i_str  (i_serial),
        .i_len  (i_serial_len),
        .i_word (4'(word_addr - `IDPB_W_SER_FIRST)),
        .o_word (ser_word)
    );

    idpb_str_word #(
        .P_CHARS (40),
        .P_JUST  (idpb_pkg::IDPB_LEFT)
    ) u_model (
        .i_str  (i_model),
        .i_len  (i_model_len),
        .i_word (5'(word_addr - `IDPB_W_MOD_FIRST)),
        .o_word (mod_word)
    );

    idpb_str_word #(
        .P_CHARS (8),
        .P_JUST  (idpb_pkg::IDPB_LEFT)
    ) u_fw (
        .i_str  (i_fw_rev),
        .i_len  (4'd8),
        .i_word (2'(word_addr - `IDPB_W_FW_FIRST)),
        .o_word (fw_word)
    );

    // byte sum through the word just taken, for the integrity word
    assign sum_acc = 8'(sum_reg + data_reg[15:8] + data_reg[7:0]);

    // content of the word at word_addr; card modes hide the dma fields except word 49 bit 8
    always_comb
    begin
        word_val = 16'h0000;
        case (word_addr) inside
            `IDPB_W_GENCFG:
                word_val = i_true_ide ? `IDPB_GENCFG_FIXED
                                      : `IDPB_GENCFG_REMOV;
            `IDPB_W_DFLT_CYL:  word_val = i_dflt_cyl;
            `IDPB_W_DFLT_HEAD: word_val = i_dflt_head;
            `IDPB_W_DFLT_SPT:  word_val = i_dflt_spt;
            `IDPB_W_CARD_LO:   word_val = i_total_sectors[15:0];
            `IDPB_W_CARD_HI:   word_val = i_total_sectors[31:16];
            [`IDPB_W_SER_FIRST:`IDPB_W_SER_LAST]: word_val = ser_word;
            [`IDPB_W_FW_FIRST:`IDPB_W_FW_LAST]:   word_val = fw_word;
            [`IDPB_W_MOD_FIRST:`IDPB_W_MOD_LAST]: word_val = mod_word;
            `IDPB_W_MAX_MULT:  word_val = {`IDPB_MAX_MULT_HI, i_max_multiple};
            `IDPB_W_CAPS:
            begin
                // bits 13 and 10 stay zero
                word_val[`IDPB_CAP_IORDY] = i_iordy_sup;
                word_val[`IDPB_CAP_LBA]   = 1'b1;
                word_val[`IDPB_CAP_DMA]   = i_dma_sup;
            end
            `IDPB_W_CAPS2:     word_val = `IDPB_CAPS2_VAL;
            `IDPB_W_PIO_MODE:  word_val = {`IDPB_PIO_MODE_HI, 8'h00};
            `IDPB_W_VALID:     word_val = `IDPB_VALID_VAL;
            `IDPB_W_CUR_CYL:   word_val = i_cur_cyl;
            `IDPB_W_CUR_HEAD:  word_val = i_cur_head;
            `IDPB_W_CUR_SPT:   word_val = i_cur_spt;
            `IDPB_W_CAP_LO:    word_val = cap_reg[15:0];
            `IDPB_W_CAP_HI:    word_val = cap_reg[31:16];
            `IDPB_W_MULT_SET:
                // any nonzero setting reports as one sector
                word_val = {`IDPB_MULT_VALID, 7'h00, |i_mult_setting};
            `IDPB_W_LBA_LO:    word_val = i_total_sectors[15:0];
            `IDPB_W_LBA_HI:    word_val = i_total_sectors[31:16];
            `IDPB_W_MDMA:
            begin
                // selection above mode 2 lives in word 163 only
                if (i_true_ide && i_mdma_sel_en && i_mdma_sel <= `IDPB_MDMA_TOP)
                    word_val[15:8] = 8'(8'h01 << i_mdma_sel);
                if (i_true_ide && i_dma_sup)
                    word_val[7:0] = thermo(i_mdma_sup_max);
            end
            `IDPB_W_ADV_PIO:
            begin
                word_val[0] = (i_pio_max >= `IDPB_PIO3);
                word_val[1] = (i_pio_max >= `IDPB_PIO4);
            end
            `IDPB_W_MDMA_MIN:
                if (i_true_ide && i_mdma_cyc_sup)
                    word_val = max16(i_mdma_min_ns, P_MDMA_FLOOR_NS);
            `IDPB_W_MDMA_REC:
                // host may run at this pace to keep requests steady
                if (i_true_ide && i_mdma_cyc_sup)
                    word_val = max16(i_mdma_rec_ns,
                                     max16(i_mdma_min_ns, P_MDMA_FLOOR_NS));
            `IDPB_W_PIO_MIN:
                if (i_pio_cyc_sup)
                    word_val = max16(i_pio_min_ns, i_pio_iordy_ns);
            `IDPB_W_PIO_IORDY: word_val = i_pio_iordy_ns;
            `IDPB_W_UDMA:
                if (i_true_ide && i_udma_sup)
                    word_val = i_udma_word;
            `IDPB_W_ADV_TIME:
                if (i_true_ide)
                    word_val = i_adv_timing;
            `IDPB_W_LAST:
                // high byte makes all 512 bytes sum to zero
                word_val = {8'(8'h00 - sum_acc - `IDPB_SIG), `IDPB_SIG};
            default:           word_val = 16'h0000;
        endcase
    end

    // handshake is combinational, data comes from flip-flops
    assign take    = (state_reg == idpb_pkg::IDPB_XFER) && i_ready;
    assign o_valid = (state_reg == idpb_pkg::IDPB_XFER);
    assign o_data  = data_reg;
    assign o_index = idx_reg;
    assign o_last  = o_valid && (idx_reg == `IDPB_W_LAST);
    assign o_done  = done_reg;

    // sequencer: one word per taken handshake, ascending, start ignored while busy
    always_comb
    begin
        state_next = state_reg;
        idx_next   = idx_reg;
        data_next  = data_reg;
        sum_next   = sum_reg;
        cap_next   = cap_reg;
        done_next  = 1'b0;
        word_addr  = 8'(idx_reg + 8'd1);
        unique case (state_reg)
            idpb_pkg::IDPB_IDLE:
            begin
                word_addr = 8'h00;
                if (i_start)
                begin
                    // capacity frozen at start so words 57-58 stay a pair
                    cap_next   = 32'(i_cur_cyl) * 32'(i_cur_head) * 32'(i_cur_spt);
                    state_next = idpb_pkg::IDPB_XFER;
                    idx_next   = 8'h00;
                    data_next  = word_val;
                    sum_next   = 8'h00;
                end
            end
            idpb_pkg::IDPB_XFER:
            begin
                if (take)
                begin
                    if (idx_reg == `IDPB_W_LAST)
                    begin
                        state_next = idpb_pkg::IDPB_IDLE;
                        done_next  = 1'b1;
                    end
                    else
                    begin
                        idx_next  = word_addr;
                        data_next = word_val;
                        sum_next  = sum_acc;
                    end
                end
            end
        endcase
    end

    // state registers
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_reg <= idpb_pkg::IDPB_IDLE;
            idx_reg   <= 8'h00;
            data_reg  <= 16'h0000;
            sum_reg   <= 8'h00;
            cap_reg   <= 32'h0000_0000;
            done_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            idx_reg   <= idx_next;
            data_reg  <= data_next;
            sum_reg   <= sum_next;
            cap_reg   <= cap_next;
            done_reg  <= done_next;
        end
    end

endmodule : idpb_top

// >>> tb/idpb_checker.sv
`timescale 1ns/1ps

// judges the identify stream; inputs steady while words flow
module idpb_checker #(
    parameter logic [15:0] P_MDMA_FLOOR_NS = 16'h0078
) (
    input wire logic        i_clk,          // clock
    input wire logic        i_rst_b,        // reset
    input wire logic        i_start,        // identify
    input wire logic        i_ready,        // taken
    input wire logic        o_valid,        // offered
    input wire logic [15:0] o_data,         // word
    input wire logic [7:0]  o_index,        // address
    input wire logic        o_last,         // word 255
    input wire logic        o_done,         // finished
    input wire logic        i_true_ide,     // ide mode
    input wire logic        i_iordy_sup,    // iordy
    input wire logic        i_dma_sup,      // dma
    input wire logic [7:0]  i_mult_setting, // multiple
    input wire logic        i_mdma_cyc_sup, // w65-66
    input wire logic [15:0] i_mdma_min_ns,  // mdma min
    input wire logic        i_pio_cyc_sup,  // w67
    input wire logic [15:0] i_pio_min_ns,   // pio min
    input wire logic [15:0] i_pio_iordy_ns  // pio iordy
);
    // one clock domain, so one default for every property
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    start_word_a: assert property (!o_valid && i_start |=> o_valid && o_index == 8'h00)
        else $error("stream did not open at word 0");
    stall_hold_a: assert property (o_valid && !i_ready |=> o_valid && $stable(o_index) && $stable(o_data))
        else $error("word changed while not taken");
    step_up_a: assert property (o_valid && i_ready && !o_last |=> o_valid && o_index == $past(o_index) + 8'h01)
        else $error("word order broken");
    end_done_a: assert property (o_last && i_ready |=> o_done && !o_valid ##1 !o_done)
        else $error("done pulse wrong");
    gencfg_a: assert property (o_valid && o_index == 8'd0 |-> o_data == (i_true_ide ? 16'h045a : 16'h848a))
        else $error("word 0 wrong");
    caps_word_a: assert property (o_valid && o_index == 8'd49 |-> o_data == {4'h0, i_iordy_sup, 2'b01, i_dma_sup, 8'h00})
        else $error("word 49 wrong");
    fixed_words_a: assert property (o_valid && (o_index == 8'd51 || o_index == 8'd53) |-> o_data == (o_index == 8'd51 ? 16'h0200 : 16'h0007))
        else $error("word 51 or 53 wrong");
    mult_set_a: assert property (o_valid && o_index == 8'd59 |-> o_data == {8'h01, 7'h00, |i_mult_setting})
        else $error("word 59 wrong");
    mdma_min_a: assert property (o_valid && o_index == 8'd65 |-> o_data == ((i_true_ide && i_mdma_cyc_sup) ?
        ((i_mdma_min_ns > P_MDMA_FLOOR_NS) ? i_mdma_min_ns : P_MDMA_FLOOR_NS) : 16'h0000))
        else $error("word 65 wrong");
    pio_min_a: assert property (o_valid && o_index == 8'd67 |-> o_data == (!i_pio_cyc_sup ? 16'h0000 :
        (i_pio_min_ns > i_pio_iordy_ns) ? i_pio_min_ns : i_pio_iordy_ns))
        else $error("word 67 wrong");

    cover property (o_last && i_ready);
    cover property (o_valid && !i_ready);
    cover property (o_valid && o_index == 8'd63 && o_data[15:8] != 8'h00);
endmodule : idpb_checker

bind idpb_top idpb_checker #(.P_MDMA_FLOOR_NS(P_MDMA_FLOOR_NS)) u_idpb_checker (.*);

// >>> tb/idpb_host_model.sv
`timescale 1ns/1ps

// host reading identify words; random stalls hold each word
module idpb_host_model (
    input  wire logic        i_clk,      // clock
    input  wire logic        i_rst_b,    // reset
    input  wire logic        i_valid,    // offered
    input  wire logic [7:0]  i_index,    // address
    input  wire logic [15:0] i_data,     // word
    input  wire logic        i_stall_en, // allow stalls
    output logic             o_ready     // taken
);
    integer      seed;
    logic [15:0] mdma_cycle_reg;

    initial seed = 32'hfff16a44;

    // ready drops about one cycle in four when stalls are allowed
    always @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_ready <= 1'b0;
            mdma_cycle_reg <= 16'h0000;
        end
        else
        begin
            o_ready <= !i_stall_en || (($random(seed) & 3) != 0);
            if (i_valid && o_ready && i_index == 8'd66)
                mdma_cycle_reg <= i_data;
        end
    end
endmodule : idpb_host_model

// >>> tb/tb.sv
`timescale 1ns/1ps
`define CHECK(act, exp) \
    begin \
        n_compared++; \
        if ((act) !== (exp)) \
        begin \
            n_fail++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, (act), (exp)); \
        end \
    end

module tb;
    localparam logic [15:0] FLOOR = 16'h0078; // dma cycle floor
    localparam int          LIMIT = 20000;    // six streams need about 1600 cycles
    logic         i_clk, i_rst_b, i_start, i_ready, o_valid, o_last, o_done, stall_en;
    logic         i_true_ide, i_iordy_sup, i_dma_sup, i_mdma_sel_en, i_mdma_cyc_sup;
    logic         i_pio_cyc_sup, i_udma_sup;
    logic [15:0]  o_data, i_dflt_cyl, i_dflt_head, i_dflt_spt, i_cur_cyl, i_cur_head, i_cur_spt;
    logic [15:0]  i_mdma_min_ns, i_mdma_rec_ns, i_pio_min_ns, i_pio_iordy_ns;
    logic [15:0]  i_udma_word, i_adv_timing;
    logic [7:0]   o_index, i_max_multiple, i_mult_setting;
    logic [31:0]  i_total_sectors;
    logic [159:0] i_serial;
    logic [319:0] i_model;
    logic [63:0]  i_fw_rev;
    logic [4:0]   i_serial_len;
    logic [5:0]   i_model_len;
    logic [2:0]   i_mdma_sup_max, i_mdma_sel, i_pio_max;
    logic [23:0]  exp_q[$];
    logic [23:0]  e;
    integer       seed, n_fail, n_compared, cycles;

    idpb_top #(.P_MDMA_FLOOR_NS(FLOOR)) u_idpb_top (
        .i_clk, .i_rst_b, .i_start, .i_ready, .o_valid, .o_data, .o_index, .o_last, .o_done,
        .i_true_ide, .i_dflt_cyl, .i_dflt_head, .i_dflt_spt, .i_cur_cyl, .i_cur_head,
        .i_cur_spt, .i_total_sectors, .i_serial, .i_serial_len, .i_fw_rev, .i_model,
        .i_model_len, .i_max_multiple, .i_mult_setting, .i_iordy_sup, .i_dma_sup,
        .i_mdma_sup_max, .i_mdma_sel_en, .i_mdma_sel, .i_pio_max, .i_mdma_cyc_sup,
        .i_mdma_min_ns, .i_mdma_rec_ns, .i_pio_cyc_sup, .i_pio_min_ns, .i_pio_iordy_ns,
        .i_udma_sup, .i_udma_word, .i_adv_timing
    );

    idpb_host_model u_idpb_host_model (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_valid(o_valid), .i_index(o_index),
        .i_data(o_data), .i_stall_en(stall_en), .o_ready(i_ready)
    );

    initial i_clk = 1'b0;
    always #50 i_clk = ~i_clk;

    // serial right justified, leading positions are spaces
    function automatic logic [7:0] ser_ch(input int p);
        int off;
        off = 20 - ((i_serial_len > 5'd20) ? 20 : int'(i_serial_len));
        return (p < off) ? 8'h20 : i_serial[(p - off) * 8 +: 8];
    endfunction : ser_ch

    function automatic logic [7:0] mod_ch(input int p);
        return (p < int'(i_model_len)) ? i_model[p * 8 +: 8] : 8'h20;
    endfunction : mod_ch

    // expected word k
    function automatic logic [15:0] exp_word(input int k);
        logic [31:0] cap;
        logic [15:0] w65, w66, w67;
        logic [7:0]  hi, lo;
        cap = i_cur_cyl * i_cur_head * i_cur_spt;
        w65 = (i_mdma_min_ns > FLOOR) ? i_mdma_min_ns : FLOOR;
        w66 = (i_mdma_rec_ns > w65) ? i_mdma_rec_ns : w65;
        w67 = (i_pio_min_ns > i_pio_iordy_ns) ? i_pio_min_ns : i_pio_iordy_ns;
        hi = (i_mdma_sel_en && i_mdma_sel <= 3'd2) ? 8'h01 << i_mdma_sel : 8'h00;
        lo = (8'h02 << ((i_mdma_sup_max > 3'd2) ? 3'd2 : i_mdma_sup_max)) - 8'h01;
        if (k >= 10 && k <= 19)
            return {ser_ch(2 * k - 20), ser_ch(2 * k - 19)};
        if (k >= 23 && k <= 26)
            return {i_fw_rev[(2 * k - 46) * 8 +: 8], i_fw_rev[(2 * k - 45) * 8 +: 8]};
        if (k >= 27 && k <= 46)
            return {mod_ch(2 * k - 54), mod_ch(2 * k - 53)};
        case (k)
            0: return i_true_ide ? 16'h045a : 16'h848a;
            1: return i_dflt_cyl;
            3: return i_dflt_head;
            6: return i_dflt_spt;
            7, 60: return i_total_sectors[15:0];
            8, 61: return i_total_sectors[31:16];
            47: return {8'h80, i_max_multiple};
            49: return {4'h0, i_iordy_sup, 2'b01, i_dma_sup, 8'h00};
            50: return 16'h4001;
            51: return 16'h0200;
            53: return 16'h0007;
            54: return i_cur_cyl;
            55: return i_cur_head;
            56: return i_cur_spt;
            57: return cap[15:0];
            58: return cap[31:16];
            59: return {8'h01, 7'h00, |i_mult_setting};
            63: return i_true_ide ? {hi, i_dma_sup ? lo : 8'h00} : 16'h0000;
            64: return {14'h0000, i_pio_max >= 3'd4, i_pio_max >= 3'd3};
            65: return (i_true_ide && i_mdma_cyc_sup) ? w65 : 16'h0000;
            66: return (i_true_ide && i_mdma_cyc_sup) ? w66 : 16'h0000;
            67: return i_pio_cyc_sup ? w67 : 16'h0000;
            68: return i_pio_iordy_ns;
            88: return (i_true_ide && i_udma_sup) ? i_udma_word : 16'h0000;
            163: return i_true_ide ? i_adv_timing : 16'h0000;
            default: return 16'h0000;
        endcase
    endfunction : exp_word

    // random configuration; streams 0 and 1 hit the length limits
    task automatic set_config(input int r);
        @(posedge i_clk);
        stall_en <= (r >= 2);
        i_true_ide <= r[0];
        {i_iordy_sup, i_dma_sup, i_mdma_sel_en, i_mdma_cyc_sup, i_pio_cyc_sup, i_udma_sup}
            <= 6'($random(seed));
        {i_mdma_sup_max, i_mdma_sel, i_pio_max} <= 9'($random(seed));
        {i_dflt_cyl, i_dflt_head} <= $random(seed);
        {i_dflt_spt, i_cur_cyl} <= $random(seed);
        {i_cur_head, i_cur_spt} <= $random(seed);
        {i_mdma_min_ns, i_mdma_rec_ns} <= $random(seed);
        {i_pio_min_ns, i_pio_iordy_ns} <= $random(seed);
        {i_udma_word, i_adv_timing} <= $random(seed);
        {i_max_multiple, i_mult_setting} <= 16'($random(seed));
        i_total_sectors <= $random(seed);
        i_fw_rev <= {$random(seed), $random(seed)};
        for (int i = 0; i < 10; i++)
            i_model[i * 32 +: 32] <= $random(seed);
        for (int i = 0; i < 5; i++)
            i_serial[i * 32 +: 32] <= $random(seed);
        i_serial_len <= (r == 0) ? 5'd20 : (r == 1) ? 5'd0 : 5'($unsigned($random(seed)) % 21);
        i_model_len <= (r == 0) ? 6'd40 : (r == 1) ? 6'd0 : 6'($unsigned($random(seed)) % 41);
        if (r == 1)
            i_mult_setting <= 8'h00;
    endtask : set_config

    // queue the block, start, refused start, then finish or abort
    task automatic run_stream(input bit abort);
        logic [15:0] w;
        logic [7:0]  sum;
        int          n;
        sum = 8'h00;
        n = 0;
        @(posedge i_clk);
        for (int k = 0; k < 255; k++)
        begin
            w = exp_word(k);
            sum = sum + w[7:0] + w[15:8];
            exp_q.push_back({8'(k), w});
        end
        exp_q.push_back({8'hff, 8'h00 - sum - 8'ha5, 8'ha5});
        i_start <= 1'b1;
        @(posedge i_clk);
        i_start <= 1'b0;
        repeat (10) @(posedge i_clk);
        i_start <= 1'b1;
        @(posedge i_clk);
        i_start <= 1'b0;
        if (abort)
        begin
            repeat (20) @(posedge i_clk);
            i_rst_b <= 1'b0;
            @(negedge i_clk);
            `CHECK({o_valid, o_data, o_index, o_done}, 26'h0000000)
            exp_q.delete();
            @(posedge i_clk);
            i_rst_b <= 1'b1;
            return;
        end
        while (o_done !== 1'b1 && n < 2000)
        begin
            @(negedge i_clk);
            n++;
        end
        `CHECK({o_valid, n < 2000, exp_q.size() == 0}, 3'b011)
    endtask : run_stream

    // each taken word meets the oldest expectation
    always @(posedge i_clk)
    begin
        if (i_rst_b && o_valid === 1'b1 && i_ready === 1'b1)
        begin
            e = (exp_q.size() == 0) ? 24'h000000 : exp_q.pop_front();
            `CHECK({o_index, o_data}, e)
        end
    end

    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            n_fail++;
            results();
        end
    end

    task automatic results;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    initial
    begin
        seed = 32'hfff16a44;
        n_fail = 0;
        n_compared = 0;
        cycles = 0;
        i_rst_b = 1'b0;
        i_start = 1'b0;
        stall_en = 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        for (int r = 0; r < 6; r++)
        begin
            set_config(r);
            run_stream(r == 4);
        end
        results();
    end
endmodule : tb
